/* File: design/uart_flow_params.svh */
// Offsets, field positions, reset values and counts of the serial buffering block
`ifndef UART_FLOW_PARAMS_SVH
`define UART_FLOW_PARAMS_SVH
`define ADDR_DATA        12'h000
`define ADDR_STATUS      12'h004
`define ADDR_CONFIG      12'h008
`define ADDR_IRQ_ENABLE  12'h00C
`define ADDR_IRQ_MODE    12'h010
`define ADDR_DMA_CONTROL 12'h014
`define ADDR_ERR_OFS_A   12'h018
`define ADDR_ERR_OFS_B   12'h01C
`define CFG_RTS_BIT      0
`define CFG_FLOW_BIT     5
`define CFG_AUTO_BIT     6
`define CFG_WIDTH        7
`define CONFIG_RESET     7'h00
`define IRQ_EN_RESET     10'h000
`define FIFO_DEPTH       4
`define RTS_MIN_FREE     2
`define OVERRUN_AHEAD    4
`define OFS_WIDTH        16
`define NO_ERROR_OFS     16'hFFFF
`endif

/* File: design/uart_flow_pkg.sv */
// Types shared by the serial buffering block
package uart_flow_pkg;
    // One receive FIFO entry: character plus its error flags
    typedef struct packed {
        logic       parity_err;
        logic       frame_err;
        logic [7:0] data;
    } rx_entry_type;
    // Interrupt event positions
    typedef enum logic [3:0] {
        EV_TX_IDLE  = 4'h0,
        EV_TX_SPACE = 4'h1,
        EV_RX_VALID = 4'h2,
        EV_TX_DONE  = 4'h3,
        EV_RX_DONE  = 4'h5,
        EV_PARITY   = 4'h7,
        EV_FRAME    = 4'h8,
        EV_OVERRUN  = 4'h9
    } irq_event_type;
endpackage : uart_flow_pkg

/* File: design/uart_flow_fifo.sv */
// Small register-based FIFO with level count
`timescale 1ns/100ps
`default_nettype none
module uart_flow_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       push,      // Ignored when full
    input  wire logic [WIDTH-1:0]           push_data,
    input  wire logic                       pop,       // Ignored when empty
    output logic      [WIDTH-1:0]           head,      // Oldest entry
    output logic      [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0]           mem_reg [DEPTH];   // Storage flops
    logic [PW-1:0]              wr_reg, wr_next;   // Write pointer
    logic [PW-1:0]              rd_reg, rd_next;   // Read pointer
    logic [$clog2(DEPTH+1)-1:0] cnt_reg, cnt_next; // Fill level
    logic                       do_push, do_pop;

    // Pointer and level update; a full FIFO keeps its contents
    always_comb
    begin
        do_push  = push && (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
        do_pop   = pop && (cnt_reg != '0);
        wr_next  = do_push ? wr_reg + 1'b1 : wr_reg;
        rd_next  = do_pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + {{($clog2(DEPTH+1)-1){1'b0}}, do_push}
                   - {{($clog2(DEPTH+1)-1){1'b0}}, do_pop};
    end

    // Registers only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage written one entry at a time; no reset needed for data
    always_ff @(posedge pclk)
    begin
        if (do_push)
        begin
            mem_reg[wr_reg] <= push_data;
        end
    end

    assign head  = mem_reg[rd_reg];
    assign count = cnt_reg;
endmodule : uart_flow_fifo
`default_nettype wire

/* File: design/uart_flow_status.sv */
// Serial port FIFOs, RTS/CTS flow control, error records and event logic
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_params.svh"
module uart_flow_status
    import uart_flow_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Transmit serializer side
    output logic      [7:0]            tx_char_data,
    output logic                       tx_char_valid,
    input  wire logic                  tx_char_ready,
    input  wire logic                  tx_shifter_busy,
    // Receive deserializer side
    input  wire logic                  rx_char_valid,
    input  wire rx_entry_type          rx_char,
    // DMA channels
    input  wire logic                  tx_dma_valid,
    input  wire logic [7:0]            tx_dma_data,
    output logic                       tx_dma_ready,
    input  wire logic                  rx_dma_pop,
    output logic                       rx_dma_ready,
    output logic      [7:0]            rx_dma_data,
    input  wire logic                  rx_dma_buf_sel,
    input  wire logic [`OFS_WIDTH-1:0] rx_dma_offset,
    input  wire logic [1:0]            tx_buffer_active,
    input  wire logic [1:0]            rx_buffer_active,
    // Flow-control pins
    input  wire logic                  clear_to_send_n,
    output logic                       request_to_send_n,
    // Interrupt line and top-level enable
    input  wire logic                  serial_top_irq_bit,
    output logic                       serial_irq
);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_CNT = DEPTH[CW-1:0];
    localparam logic [CW-1:0] RTS_MAX_CNT = CW'(DEPTH - `RTS_MIN_FREE);

    // Register file and status
    logic [`CFG_WIDTH-1:0]  line_config_reg, line_config_next;
    logic [9:0]             serial_irq_enable_reg, serial_irq_enable_next;
    logic                   irq_edge_level_select_reg, irq_edge_level_select_next;
    logic [31:0]            prdata_reg, prdata_next;
    logic                   slverr_reg, slverr_next;
    logic                   rd_had_data_reg, rd_had_data_next; // Head valid at setup
    logic                   rx_overrun_flag_reg, rx_overrun_flag_next;
    logic [`OFS_WIDTH-1:0]  rx_error_offset_reg [2];
    logic [`OFS_WIDTH-1:0]  err_ofs_next [2];
    logic [31:0]            uart_line_status;
    // Pins and flow control
    logic                   cts_meta_reg, cts_sync_reg;      // Synchroniser
    logic                   request_to_send_n_reg, rts_next;
    // Event edge history
    logic [2:0]             flag_prev_reg;
    logic [1:0]             tx_act_prev_reg, rx_act_prev_reg;
    logic [9:0]             irq_event_reg, irq_event_next;
    // FIFO wiring
    logic                   tx_push, rx_push, tx_pop, rx_pop;
    logic [7:0]             tx_push_data, tx_head;
    rx_entry_type           rx_head;
    logic [CW-1:0]          tx_count, rx_count;
    logic                   tx_full, tx_empty, rx_full, rx_empty;
    logic                   setup, access, wr_acc, rd_acc;
    logic                   data_wr, data_rd, overrun_now;
    logic                   tx_idle_flag, tx_space_flag, rx_valid_flag;
    logic                   clear_to_send_state, handshake_enable, auto_request_control;
    logic [2:0]             flags_now;

    // APB phases
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign wr_acc  = access && pwrite;
    assign rd_acc  = access && !pwrite;
    assign data_wr = wr_acc && (paddr == `ADDR_DATA);
    assign data_rd = rd_acc && (paddr == `ADDR_DATA);

    // Configuration fields
    assign handshake_enable     = line_config_reg[`CFG_FLOW_BIT];
    assign auto_request_control = line_config_reg[`CFG_AUTO_BIT];
    assign clear_to_send_state  = !cts_sync_reg;

    // FIFO levels
    assign tx_full  = (tx_count == FULL_CNT);
    assign tx_empty = (tx_count == '0);
    assign rx_full  = (rx_count == FULL_CNT);
    assign rx_empty = (rx_count == '0);

    // Software write wins the transmit FIFO; the DMA is held off that cycle
    assign tx_push      = (data_wr || tx_dma_valid) && !tx_full;
    assign tx_push_data = data_wr ? pwdata[7:0] : tx_dma_data;
    assign tx_dma_ready = !tx_full && !data_wr;

    // Software pop wins the receive FIFO over the DMA
    assign rx_pop       = (data_rd && rd_had_data_reg) || (rx_dma_pop && rx_dma_ready);
    assign rx_dma_ready = !rx_empty && !data_rd;
    assign rx_dma_data  = rx_head.data;
    // A full FIFO refuses the new character and keeps its entries
    assign rx_push      = rx_char_valid && !rx_full;
    assign overrun_now  = rx_char_valid && rx_full;

    // Start of a character gated by CTS; serializer finishes any started one
    assign tx_char_valid = !tx_empty && (!handshake_enable || clear_to_send_state);
    assign tx_char_data  = tx_head;
    assign tx_pop        = tx_char_valid && tx_char_ready;

    uart_flow_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (tx_push),
        .push_data (tx_push_data),
        .pop       (tx_pop),
        .head      (tx_head),
        .count     (tx_count)
    );

    uart_flow_fifo #(.WIDTH(10), .DEPTH(DEPTH)) rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (rx_push),
        .push_data (rx_char),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_count)
    );

    // Status flags
    assign tx_idle_flag  = tx_empty && !tx_shifter_busy;
    assign tx_space_flag = !tx_full;
    assign rx_valid_flag = !rx_empty;
    assign flags_now     = {rx_valid_flag, tx_space_flag, tx_idle_flag};

    // Error flags follow the presented character, cleared while empty
    assign uart_line_status = {25'h000_0000, tx_idle_flag,
                               rx_head.parity_err && !rx_empty,
                               rx_head.frame_err && !rx_empty,
                               rx_overrun_flag_reg, tx_space_flag,
                               rx_valid_flag, clear_to_send_state};

    // Register writes, read capture, overrun flag and error offsets
    always_comb
    begin
        line_config_next           = line_config_reg;
        serial_irq_enable_next     = serial_irq_enable_reg;
        irq_edge_level_select_next = irq_edge_level_select_reg;
        prdata_next                = prdata_reg;
        slverr_next                = 1'b0;
        rd_had_data_next           = rd_had_data_reg;
        err_ofs_next               = rx_error_offset_reg;
        // Overrun set beats the clearing read in the same cycle
        rx_overrun_flag_next = overrun_now || (rx_overrun_flag_reg && !data_rd);
        if (setup)
        begin
            // Read data is sampled in setup and held through the access phase
            rd_had_data_next = !rx_empty;
            unique case (paddr)
                `ADDR_DATA:        prdata_next = {24'h00_0000, rx_head.data};
                `ADDR_STATUS:      prdata_next = uart_line_status;
                `ADDR_CONFIG:      prdata_next = {25'h000_0000, line_config_reg};
                `ADDR_IRQ_ENABLE:  prdata_next = {22'h00_0000, serial_irq_enable_reg};
                `ADDR_IRQ_MODE:    prdata_next = {31'h0000_0000, irq_edge_level_select_reg};
                `ADDR_DMA_CONTROL: prdata_next = 32'h0000_0000;
                `ADDR_ERR_OFS_A:   prdata_next = {16'h0000, rx_error_offset_reg[0]};
                `ADDR_ERR_OFS_B:   prdata_next = {16'h0000, rx_error_offset_reg[1]};
                default:
                begin
                    prdata_next = 32'h0000_0000;
                    slverr_next = 1'b1;                     // Unmapped address
                end
            endcase
        end
        if (wr_acc && !slverr_reg)
        begin
            unique case (paddr)
                `ADDR_CONFIG:     line_config_next = pwdata[`CFG_WIDTH-1:0];
                `ADDR_IRQ_ENABLE: serial_irq_enable_next = pwdata[9:0];
                `ADDR_IRQ_MODE:   irq_edge_level_select_next = pwdata[0];
                default:          ;
            endcase
        end
        // First error per buffer is kept until cleared
        for (int b = 0; b < 2; b++)
        begin
            if (wr_acc && (paddr == `ADDR_DMA_CONTROL) && pwdata[b])
            begin
                err_ofs_next[b] = `NO_ERROR_OFS;
            end
            else if (rx_buffer_active[b] && !rx_act_prev_reg[b])
            begin
                err_ofs_next[b] = `NO_ERROR_OFS;
            end
            else if (rx_error_offset_reg[b] == `NO_ERROR_OFS && rx_dma_buf_sel == b[0])
            begin
                if (overrun_now)
                begin
                    // Offset lands where the DMA will be once the FIFO drains
                    err_ofs_next[b] = rx_dma_offset + `OFS_WIDTH'(`OVERRUN_AHEAD);
                end
                else if (rx_dma_pop && rx_dma_ready
                         && (rx_head.parity_err || rx_head.frame_err))
                begin
                    err_ofs_next[b] = rx_dma_offset;
                end
            end
        end
    end

    // Request-to-send pin: automatic from FIFO room, else software bit
    always_comb
    begin
        if (handshake_enable && auto_request_control)
        begin
            rts_next = (rx_count > RTS_MAX_CNT);
        end
        else
        begin
            rts_next = !line_config_reg[`CFG_RTS_BIT];
        end
    end

    // Events: level or rising edge of flags, DMA completions, receive errors
    always_comb
    begin
        irq_event_next = '0;
        for (int i = 0; i < 3; i++)
        begin
            irq_event_next[i] = flags_now[i]
                && (irq_edge_level_select_reg || !flag_prev_reg[i]);
        end
        irq_event_next[EV_TX_DONE +: 2] = tx_act_prev_reg & ~tx_buffer_active;
        irq_event_next[EV_RX_DONE +: 2] = rx_act_prev_reg & ~rx_buffer_active;
        irq_event_next[EV_PARITY]  = rx_push && rx_char.parity_err;
        irq_event_next[EV_FRAME]   = rx_push && rx_char.frame_err;
        irq_event_next[EV_OVERRUN] = overrun_now;
    end

    // All control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_config_reg           <= `CONFIG_RESET;
            serial_irq_enable_reg     <= `IRQ_EN_RESET;
            irq_edge_level_select_reg <= 1'b0;
            prdata_reg                <= 32'h0000_0000;
            slverr_reg                <= 1'b0;
            rd_had_data_reg           <= 1'b0;
            rx_overrun_flag_reg       <= 1'b0;
            rx_error_offset_reg[0]    <= `NO_ERROR_OFS;
            rx_error_offset_reg[1]    <= `NO_ERROR_OFS;
            cts_meta_reg              <= 1'b1;
            cts_sync_reg              <= 1'b1;
            request_to_send_n_reg     <= 1'b1;      // Lines rest high
            flag_prev_reg             <= 3'h0;
            tx_act_prev_reg           <= 2'h0;
            rx_act_prev_reg           <= 2'h0;
            irq_event_reg             <= 10'h000;
        end
        else
        begin
            line_config_reg           <= line_config_next;
            serial_irq_enable_reg     <= serial_irq_enable_next;
            irq_edge_level_select_reg <= irq_edge_level_select_next;
            prdata_reg                <= prdata_next;
            slverr_reg                <= slverr_next;
            rd_had_data_reg           <= rd_had_data_next;
            rx_overrun_flag_reg       <= rx_overrun_flag_next;
            rx_error_offset_reg       <= err_ofs_next;
            cts_meta_reg              <= clear_to_send_n;
            cts_sync_reg              <= cts_meta_reg;
            request_to_send_n_reg     <= rts_next;
            flag_prev_reg             <= flags_now;
            tx_act_prev_reg           <= tx_buffer_active;
            rx_act_prev_reg           <= rx_buffer_active;
            irq_event_reg             <= irq_event_next;
        end
    end

    // Outputs; the line needs both the local enable and the top enable
    assign request_to_send_n = request_to_send_n_reg;
    assign serial_irq = serial_top_irq_bit && |(irq_event_reg & serial_irq_enable_reg);
    assign prdata  = prdata_reg;
    assign pready  = access;          // Zero wait states
    assign pslverr = access && slverr_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    auto_rts_level_a: assert property (handshake_enable && auto_request_control
        |=> request_to_send_n == ($past(rx_count) > RTS_MAX_CNT))
        else $error("auto request level wrong");
    soft_rts_level_a: assert property (!auto_request_control
        |=> request_to_send_n == !$past(line_config_reg[`CFG_RTS_BIT]))
        else $error("soft request level wrong");
    cts_gate_a: assert property (tx_char_valid && handshake_enable
        |-> $past(!clear_to_send_n, 2))
        else $error("start while clear-to-send high");
    overrun_flag_set_a: assert property (overrun_now |=> rx_overrun_flag_reg)
        else $error("overrun flag missed");
    overrun_clear_a: assert property (data_rd && !overrun_now
        |=> !rx_overrun_flag_reg)
        else $error("overrun flag not cleared");
    overrun_irq_a: assert property (overrun_now && serial_irq_enable_reg[EV_OVERRUN]
        && serial_top_irq_bit ##1 serial_top_irq_bit |-> serial_irq)
        else $error("overrun interrupt late");
    drop_keeps_fifo_a: assert property (overrun_now && !rx_pop
        |=> rx_count == FULL_CNT && $stable(rx_head))
        else $error("full FIFO disturbed");
    data_pop_a: assert property (data_rd && rd_had_data_reg && !rx_push
        |=> rx_count == $past(rx_count) - 1'b1)
        else $error("data read did not pop");
    data_push_a: assert property (data_wr && !tx_full && !tx_pop
        |=> tx_count == $past(tx_count) + 1'b1)
        else $error("data write did not push");
    idle_status_a: assert property (uart_line_status[6]
        == (tx_count == '0 && !tx_shifter_busy))
        else $error("idle status wrong");
    buf_done_a: assert property (tx_buffer_active[0] ##1 !tx_buffer_active[0]
        |=> irq_event_reg[EV_TX_DONE])
        else $error("buffer complete missed");
    reload_clear_a: assert property (rx_buffer_active[1] && !rx_act_prev_reg[1]
        |=> rx_error_offset_reg[1] == `NO_ERROR_OFS)
        else $error("reload did not clear offset");
endmodule : uart_flow_status
`default_nettype wire

/* File: test/uart_far_side_model.sv */
// Far-side model: character serializer plus a remote sender that obeys the request pin
`timescale 1ns/100ps
`default_nettype none
module uart_far_side_model
    import uart_flow_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   [7:0] tx_char_data,
    input  wire logic   tx_char_valid,
    output logic        tx_char_ready,
    output logic        tx_shifter_busy,
    input  wire logic   request_to_send_n,
    input  wire logic   send_req,           // Bench asks for one character per cycle
    output logic        rx_char_valid,
    output var rx_entry_type rx_char,
    output logic        [7:0] last_tx,      // Last character taken by the shifter
    output logic        [3:0] tx_count      // Characters taken so far
);
    logic [1:0] busy_reg;                   // Shortened frame time left
    logic [7:0] seq_reg;                    // Next character to send
    assign tx_shifter_busy = (busy_reg != 2'h0);
    // Shifter refuses a new character until the current frame ends
    assign tx_char_ready = !tx_shifter_busy;
    // Shifter and sender state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_reg <= 2'h0;
            seq_reg <= 8'ha0;
            rx_char_valid <= 1'b0;
            rx_char <= 10'h3ff;
            last_tx <= 8'h00;
            tx_count <= 4'h0;
        end
        else
        begin
            busy_reg <= (tx_char_valid && tx_char_ready) ? 2'h3 : busy_reg - {1'b0, tx_shifter_busy};
            if (tx_char_valid && tx_char_ready)
            begin
                last_tx <= tx_char_data;
                tx_count <= tx_count + 4'h1;
            end
            // No new character once the request pin is high
            rx_char_valid <= send_req && !request_to_send_n;
            // Idle data toggles so nothing stale can pass for a character
            // First character carries a parity error, character a8 a framing error
            rx_char <= (send_req && !request_to_send_n)
                       ? {seq_reg == 8'ha0, seq_reg == 8'ha8, seq_reg} : ~rx_char;
            if (send_req && !request_to_send_n)
                seq_reg <= seq_reg + 8'h01;
        end
    end
endmodule : uart_far_side_model
`default_nettype wire

/* File: test/uart_flow_status_tb.sv */
// Self-checking bench for the serial buffering and flow-control block
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_params.svh"
module uart_flow_status_tb
    import uart_flow_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    logic pready, pslverr, slverr, tx_char_valid, tx_char_ready, tx_shifter_busy;
    logic tx_dma_ready, rx_dma_ready;
    logic rx_char_valid, request_to_send_n, serial_irq, send_req = 1'b0;
    logic [7:0] tx_char_data, last_tx, rx_dma_data, tx_dma_data = 8'h00;
    rx_entry_type rx_char;
    logic tx_dma_valid = 1'b0, rx_dma_pop = 1'b0, rx_dma_buf_sel = 1'b0;
    logic clear_to_send_n = 1'b1, serial_top_irq_bit = 1'b1;
    logic [15:0] rx_dma_offset = 16'h0010;  // Offset that an overrun is recorded against
    logic [1:0] tx_buffer_active = 2'h0, rx_buffer_active = 2'h0;
    logic [3:0] tx_count;
    int n_errors = 0, check_count = 0;
    always #4 pclk = ~pclk;
    uart_flow_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tx_char_data, .tx_char_valid, .tx_char_ready, .tx_shifter_busy,
        .rx_char_valid, .rx_char, .tx_dma_valid, .tx_dma_data, .tx_dma_ready, .rx_dma_pop,
        .rx_dma_ready, .rx_dma_data, .rx_dma_buf_sel, .rx_dma_offset, .tx_buffer_active,
        .rx_buffer_active, .clear_to_send_n, .request_to_send_n, .serial_top_irq_bit, .serial_irq);
    uart_far_side_model far (.pclk, .presetn, .tx_char_data, .tx_char_valid, .tx_char_ready,
        .tx_shifter_busy, .request_to_send_n, .send_req, .rx_char_valid, .rx_char, .last_tx,
        .tx_count);
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            summarize();
        end
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), exp, rdata);
    endtask : rd
    // Remote side sends one character per cycle for n cycles
    task automatic send(input int n);
        @(posedge pclk);
        send_req <= 1'b1;
        repeat (n) @(posedge pclk);
        send_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : send
    // Waits until the shifter has taken n characters and gone idle; bounded
    task automatic wait_tx(input logic [3:0] n);
        int i;
        for (i = 0; i < 60 && !(tx_count === n && tx_shifter_busy === 1'b0); i++)
            @(posedge pclk);
        if (i == 60)
        begin
            n_errors++;
            summarize();
        end
    endtask : wait_tx
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_STATUS, 32'h0000_0044);
        apb(1'b1, `ADDR_CONFIG, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("rts_n", 32'h0000_0000, 32'(request_to_send_n));
        apb(1'b1, `ADDR_CONFIG, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk("rts_n", 32'h0000_0001, 32'(request_to_send_n));
        apb(1'b1, `ADDR_CONFIG, 32'h0000_0001);
        send(5);
        rd(`ADDR_STATUS, 32'h0000_006e);
        rd(`ADDR_ERR_OFS_A, 32'h0000_0014);
        for (int k = 0; k < 4; k++)
            rd(`ADDR_DATA, 32'h0000_00a0 + k);
        rd(`ADDR_STATUS, 32'h0000_0044);
        apb(1'b1, `ADDR_CONFIG, 32'h0000_0060);
        apb(1'b1, `ADDR_DATA, 32'h0000_005a);
        apb(1'b1, `ADDR_DATA, 32'h0000_003c);
        repeat (20) @(posedge pclk);
        chk("tx count", 32'h0000_0000, 32'(tx_count));
        clear_to_send_n <= 1'b0;
        wait_tx(4'h2);
        chk("last tx", 32'h0000_003c, 32'(last_tx));
        rd(`ADDR_STATUS, 32'h0000_0045);
        apb(1'b1, `ADDR_IRQ_MODE, 32'h0000_0001);
        apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0000_0004);
        send(3);
        chk("rts_n", 32'h0000_0001, 32'(request_to_send_n));
        chk("irq", 32'h0000_0001, 32'(serial_irq));
        serial_top_irq_bit <= 1'b0;
        @(posedge pclk);
        chk("irq", 32'h0000_0000, 32'(serial_irq));
        serial_top_irq_bit <= 1'b1;
        rd(`ADDR_DATA, 32'h0000_00a5);
        repeat (2) @(posedge pclk);
        chk("rts_n", 32'h0000_0000, 32'(request_to_send_n));
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, 32'(slverr));
        // Receive DMA drains a6, a7 and the framed a8 after the record is cleared
        send(1);
        apb(1'b1, `ADDR_DMA_CONTROL, 32'h0000_0001);
        rx_dma_pop <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            rx_dma_offset <= 16'h0020 + 16'(k);
            @(posedge pclk);
            chk("rx dma ready", 32'h0000_0001, 32'(rx_dma_ready));
            chk("rx dma data", 32'h0000_00a6 + k, 32'(rx_dma_data));
        end
        rx_dma_pop <= 1'b0;
        rd(`ADDR_ERR_OFS_A, 32'h0000_0022);
        // Buffer reload clears the record; completion gives a one-cycle edge event
        apb(1'b1, `ADDR_IRQ_MODE, 32'h0000_0000);
        apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0000_0020);
        tx_buffer_active <= 2'h1;
        rx_buffer_active <= 2'h3;
        rd(`ADDR_ERR_OFS_A, 32'h0000_ffff);
        tx_buffer_active <= 2'h0;
        rx_buffer_active <= 2'h0;
        repeat (2) @(posedge pclk);
        chk("done irq", 32'h0000_0001, 32'(serial_irq));
        @(posedge pclk);
        chk("done irq", 32'h0000_0000, 32'(serial_irq));
        // Transmit DMA loads one character that the shifter then sends
        tx_dma_data  <= 8'h77;
        tx_dma_valid <= 1'b1;
        @(posedge pclk);
        chk("tx dma ready", 32'h0000_0001, 32'(tx_dma_ready));
        tx_dma_valid <= 1'b0;
        wait_tx(4'h3);
        chk("last tx", 32'h0000_0077, 32'(last_tx));
        summarize();
    end
endmodule : uart_flow_status_tb
`default_nettype wire
